/* File: rtl/rpds_pkg.sv */
// run permit and dwell sequencer: shared constants, types and helper functions
// Function
// - a terminal whose function select is 13 is the run permit; five terminals
// - permit source 0 means always permitted, 1 means the permit terminal decides
// - permit-loss stop action 0-2, default 0: coast, quick halt, quick halt with resume
// - coast action blocks the output at once when the permit drops
// - quick halt ramps to zero over the quick-halt time, restart needs a new run
// - in quick halt, permit returning alone never starts the drive
// - quick halt with resume restarts once permit and run are both on
// - quick-halt time 0.0-600.0 s in 0.1 s steps, default 5.0 s
// - first acceleration holds at the acceleration hold frequency for its time
// - a stop ramps to the deceleration hold frequency, holds, then stops
// - a hold with zero time or zero frequency is skipped
// - only the first acceleration after a run command may hold
// - deceleration hold only on stop commands, never with external brake control
// - hold frequencies clamped to start..max, default 5.00 Hz; times default 0.0 s
// - holds are supported only in volts-per-hertz control mode
`default_nettype none

package rpds_pkg;

    localparam int APB_AW          = 8;
    localparam int APB_DW          = 32;
    localparam int N_TERM          = 5;
    localparam int SEL_W           = 6;
    localparam int FRAC_W          = 16;

    // timing: 1 ms tick, holds and ramps are counted in tenths of a second
    localparam int CLK_PERIOD_NS   = 8;
    localparam int TICK_PERIOD_NS  = 1000000;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_TENTH = 100;

    // register offsets
    localparam logic [APB_AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [APB_AW-1:0] OFS_TERMSEL = 8'h04;
    localparam logic [APB_AW-1:0] OFS_QHALT   = 8'h08;
    localparam logic [APB_AW-1:0] OFS_TARGET  = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_LIMITS  = 8'h10;
    localparam logic [APB_AW-1:0] OFS_RAMP    = 8'h14;
    localparam logic [APB_AW-1:0] OFS_ACC_DW  = 8'h18;
    localparam logic [APB_AW-1:0] OFS_DEC_DW  = 8'h1C;
    localparam logic [APB_AW-1:0] OFS_STATUS  = 8'h20;

    // control and status register fields
    localparam int CTRL_SRC_BIT    = 0;
    localparam int CTRL_ACT_LSB    = 1;
    localparam int CTRL_BRAKE_BIT  = 3;
    localparam int CTRL_MODE_LSB   = 4;
    localparam int HI_LSB          = 16;
    localparam int ST_STATE_LSB    = 16;
    localparam int ST_PERMIT_BIT   = 19;
    localparam int ST_BLOCK_BIT    = 20;

    localparam logic [SEL_W-1:0] PERMIT_CODE = 6'h0D;
    localparam logic [1:0] ACT_COAST   = 2'h0;
    localparam logic [1:0] ACT_QHALT   = 2'h1;
    localparam logic [1:0] ACT_QRESUME = 2'h2;
    localparam logic [1:0] MODE_VF     = 2'h0;

    // reset values and limits (frequency in 0.01 Hz, time in 0.1 s)
    localparam logic       SRC_RST        = 1'b1;
    localparam logic [15:0] QHALT_RST     = 16'h0032;
    localparam logic [15:0] QHALT_MAX     = 16'h1770;
    localparam logic [15:0] DW_FREQ_RST   = 16'h01F4;
    localparam logic [15:0] DW_TIME_RST   = 16'h0000;
    localparam logic [15:0] ACC_DW_MAX    = 16'h0064;
    localparam logic [15:0] DEC_DW_MAX    = 16'h0258;
    localparam logic [15:0] FMAX_RST      = 16'h1770;
    localparam logic [15:0] FSTART_RST    = 16'h0032;
    localparam logic [15:0] RAMP_TIME_RST = 16'h0032;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_RUN      = 3'h1,
        ST_ACC_HOLD = 3'h2,
        ST_STOPPING = 3'h3,
        ST_DEC_HOLD = 3'h4,
        ST_QHALT    = 3'h5
    } rpds_state_e;

    typedef struct packed {
        logic                    permit_src;
        logic [1:0]              stop_act;
        logic                    brake_ctl;
        logic [1:0]              ctrl_mode;
        logic [N_TERM*SEL_W-1:0] term_sel;
        logic [15:0]             qhalt_time;
        logic [15:0]             target;
        logic [15:0]             fmax;
        logic [15:0]             fstart;
        logic [15:0]             acc_time;
        logic [15:0]             dec_time;
        logic [15:0]             acc_dw_freq;
        logic [15:0]             acc_dw_time;
        logic [15:0]             dec_dw_freq;
        logic [15:0]             dec_dw_time;
    } rpds_cfg_s;

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        if (v < lo)
            clamp16 = lo;
        else if (v > hi)
            clamp16 = hi;
        else
            clamp16 = v;
    endfunction

    // per-tick increment, fixed point, for a full-scale ramp over tenths seconds
    function automatic logic [31:0] ramp_inc(input logic [15:0] span, input logic [15:0] tenths);
        logic [31:0] den;
        logic [31:0] num;
        den = 32'(tenths) * 32'(TICKS_PER_TENTH);
        num = {span, 16'h0000};
        if (den == 32'h0000_0000)
            ramp_inc = num;
        else
            ramp_inc = num / den;
        if (ramp_inc == 32'h0000_0000)
            ramp_inc = 32'h0000_0001;
    endfunction

endpackage

`default_nettype wire

/* File: rtl/rpds_sync3.sv */
// three-stage pin synchroniser, output follows once stages two and three agree
`default_nettype none

module rpds_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,     // core clock
    input  wire logic             reset_n, // synchronous reset, active low
    input  wire logic [WIDTH-1:0] d,       // asynchronous pin levels
    output logic      [WIDTH-1:0] q        // filtered levels
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q     <= '0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // a disagreement keeps the old level, which filters single-cycle glitches
            q     <= (s2_ff & s3_ff) | (q & (s2_ff | s3_ff));
        end
    end

endmodule

`default_nettype wire

/* File: rtl/rpds_sequencer.sv */
// run permit gating, stop actions and acc/dec dwell sequencing with APB registers
`default_nettype none

module rpds_sequencer #(
    parameter int TICK_CYC = rpds_pkg::TICK_CYCLES
) (
    input  wire logic                         CORE_CLK, // core clock, 125 MHz
    input  wire logic                         RESET_N,  // synchronous reset, active low
    input  wire logic                         PSEL,     // apb select
    input  wire logic                         PENABLE,  // apb enable
    input  wire logic                         PWRITE,   // apb direction
    input  wire logic [rpds_pkg::APB_AW-1:0]  PADDR,    // apb byte address
    input  wire logic [rpds_pkg::APB_DW-1:0]  PWDATA,   // apb write data
    output logic      [rpds_pkg::APB_DW-1:0]  PRDATA,   // apb read data
    output logic                              PREADY,   // apb ready
    output logic                              PSLVERR,  // apb error, unmapped address
    input  wire logic [rpds_pkg::N_TERM-1:0]  TERM_IN,  // multi-function terminal levels
    input  wire logic                         RUN_IN,   // run command level
    output logic      [15:0]                  FREQ_REF, // frequency reference, 0.01 Hz
    output logic                              OUT_BLOCK // block power stage output
);

    import rpds_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and tick

    logic [N_TERM:0] pins_sync;
    logic [31:0]     div_ff;
    logic            tick_ff;
    logic            run_q_ff;
    logic            run_lvl;
    logic            run_rise;

    rpds_sync3 #(
        .WIDTH (N_TERM + 1)
    ) u_sync (
        .clk     (CORE_CLK),
        .reset_n (RESET_N),
        .d       ({RUN_IN, TERM_IN}),
        .q       (pins_sync)
    );

    assign run_lvl  = pins_sync[N_TERM];
    assign run_rise = run_lvl & ~run_q_ff;

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(TICK_CYC - 1)) begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N)
            run_q_ff <= 1'b0;
        else
            run_q_ff <= run_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    rpds_cfg_s   cfg_ff;
    rpds_state_e state_ff;
    logic [31:0] freq_ff;
    logic        block_ff;
    logic        permit;
    logic        term_permit;
    logic        setup;
    logic        wr_en;
    logic        hit;
    logic [31:0] rd_val;

    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            cfg_ff             <= '0;
            cfg_ff.permit_src  <= SRC_RST;
            cfg_ff.stop_act    <= ACT_COAST;
            cfg_ff.ctrl_mode   <= MODE_VF;
            cfg_ff.qhalt_time  <= QHALT_RST;
            cfg_ff.fmax        <= FMAX_RST;
            cfg_ff.fstart      <= FSTART_RST;
            cfg_ff.acc_time    <= RAMP_TIME_RST;
            cfg_ff.dec_time    <= RAMP_TIME_RST;
            cfg_ff.acc_dw_freq <= DW_FREQ_RST;
            cfg_ff.acc_dw_time <= DW_TIME_RST;
            cfg_ff.dec_dw_freq <= DW_FREQ_RST;
            cfg_ff.dec_dw_time <= DW_TIME_RST;
        end else if (wr_en) begin
            case (PADDR)
                OFS_CTRL: begin
                    cfg_ff.permit_src <= PWDATA[CTRL_SRC_BIT];
                    // stop action, out-of-range code falls back to coast
                    cfg_ff.stop_act   <= (PWDATA[CTRL_ACT_LSB +: 2] > ACT_QRESUME) ?
                                         ACT_COAST : PWDATA[CTRL_ACT_LSB +: 2];
                    cfg_ff.brake_ctl  <= PWDATA[CTRL_BRAKE_BIT];
                    cfg_ff.ctrl_mode  <= PWDATA[CTRL_MODE_LSB +: 2];
                end
                OFS_TERMSEL: begin
                    cfg_ff.term_sel <= PWDATA[N_TERM*SEL_W-1:0];
                end
                OFS_QHALT: begin
                    cfg_ff.qhalt_time <= clamp16(PWDATA[15:0], 16'h0000, QHALT_MAX);
                end
                OFS_TARGET: begin
                    cfg_ff.target <= PWDATA[15:0];
                end
                OFS_LIMITS: begin
                    cfg_ff.fmax   <= PWDATA[15:0];
                    cfg_ff.fstart <= PWDATA[HI_LSB +: 16];
                end
                OFS_RAMP: begin
                    cfg_ff.acc_time <= PWDATA[15:0];
                    cfg_ff.dec_time <= PWDATA[HI_LSB +: 16];
                end
                OFS_ACC_DW: begin
                    cfg_ff.acc_dw_freq <= PWDATA[15:0];
                    cfg_ff.acc_dw_time <= clamp16(PWDATA[HI_LSB +: 16], 16'h0000, ACC_DW_MAX);
                end
                OFS_DEC_DW: begin
                    cfg_ff.dec_dw_freq <= PWDATA[15:0];
                    cfg_ff.dec_dw_time <= clamp16(PWDATA[HI_LSB +: 16], 16'h0000, DEC_DW_MAX);
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb read side: zero wait state, answer prepared in the setup cycle

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (PADDR)
            OFS_CTRL: begin
                rd_val[CTRL_SRC_BIT]       = cfg_ff.permit_src;
                rd_val[CTRL_ACT_LSB +: 2]  = cfg_ff.stop_act;
                rd_val[CTRL_BRAKE_BIT]     = cfg_ff.brake_ctl;
                rd_val[CTRL_MODE_LSB +: 2] = cfg_ff.ctrl_mode;
            end
            OFS_TERMSEL: rd_val[N_TERM*SEL_W-1:0] = cfg_ff.term_sel;
            OFS_QHALT:   rd_val[15:0] = cfg_ff.qhalt_time;
            OFS_TARGET:  rd_val[15:0] = cfg_ff.target;
            OFS_LIMITS:  rd_val = {cfg_ff.fstart, cfg_ff.fmax};
            OFS_RAMP:    rd_val = {cfg_ff.dec_time, cfg_ff.acc_time};
            OFS_ACC_DW:  rd_val = {cfg_ff.acc_dw_time, cfg_ff.acc_dw_freq};
            OFS_DEC_DW:  rd_val = {cfg_ff.dec_dw_time, cfg_ff.dec_dw_freq};
            OFS_STATUS: begin
                rd_val[15:0]              = freq_ff[FRAC_W +: 16];
                rd_val[ST_STATE_LSB +: 3] = state_ff;
                rd_val[ST_PERMIT_BIT]     = permit;
                rd_val[ST_BLOCK_BIT]      = block_ff;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~hit;
            if (setup) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // permit decode and dwell settings

    always_comb begin
        term_permit = 1'b0;
        // any terminal selected as run permit
        for (int i = 0; i < N_TERM; i++) begin
            if (cfg_ff.term_sel[i*SEL_W +: SEL_W] == PERMIT_CODE && pins_sync[i])
                term_permit = 1'b1;
        end
    end

    assign permit = ~cfg_ff.permit_src | term_permit;

    logic [15:0] cur;
    logic [15:0] tgt;
    logic [15:0] acc_dwf;
    logic [15:0] dec_dwf;
    logic        acc_dw_en;
    logic        dec_dw_en;
    logic        dw_goal;
    logic [31:0] acc_hold_lim;
    logic [31:0] dec_hold_lim;
    logic [15:0] goal;
    logic [15:0] rate;
    logic [31:0] goal_fx;
    logic [31:0] inc;
    logic [31:0] stepped;
    logic        at_goal;
    logic [15:0] hold_cnt_ff;
    logic        acc_pend_ff;
    logic        dec_pass_ff;
    logic        need_fresh_ff;
    logic        start;

    assign cur     = freq_ff[FRAC_W +: 16];
    assign tgt     = clamp16(cfg_ff.target, 16'h0000, cfg_ff.fmax);
    assign acc_dwf = clamp16(cfg_ff.acc_dw_freq, cfg_ff.fstart, cfg_ff.fmax);
    assign dec_dwf = clamp16(cfg_ff.dec_dw_freq, cfg_ff.fstart, cfg_ff.fmax);
    assign acc_dw_en = cfg_ff.acc_dw_time != 16'h0000 && cfg_ff.acc_dw_freq != 16'h0000 &&
                       cfg_ff.ctrl_mode == MODE_VF;
    assign dec_dw_en = cfg_ff.dec_dw_time != 16'h0000 && cfg_ff.dec_dw_freq != 16'h0000 &&
                       cfg_ff.ctrl_mode == MODE_VF;
    assign acc_hold_lim = 32'(cfg_ff.acc_dw_time) * 32'(TICKS_PER_TENTH);
    assign dec_hold_lim = 32'(cfg_ff.dec_dw_time) * 32'(TICKS_PER_TENTH);
    // hold only while the first acceleration is pending
    assign dw_goal = acc_pend_ff && acc_dw_en && tgt > acc_dwf;
    // a fresh run edge is needed after a quick halt
    assign start   = permit && run_lvl && (!need_fresh_ff || run_rise);

    ////////////////////////////////////////////////////////////////////////////
    // ramp generator

    always_comb begin
        goal = 16'h0000;
        case (state_ff)
            ST_RUN:      goal = dw_goal ? acc_dwf : tgt;
            ST_ACC_HOLD: goal = cur;
            ST_DEC_HOLD: goal = cur;
            ST_STOPPING: goal = dec_pass_ff ? dec_dwf : 16'h0000;
            default:     goal = 16'h0000;
        endcase
        goal_fx = {goal, 16'h0000};
        // quick halt uses its own time
        if (state_ff == ST_QHALT)
            rate = cfg_ff.qhalt_time;
        else if (goal_fx > freq_ff)
            rate = cfg_ff.acc_time;
        else
            rate = cfg_ff.dec_time;
        // increment per tick; rates are referred to the maximum frequency
        inc = ramp_inc(cfg_ff.fmax, rate);
        if (freq_ff < goal_fx)
            stepped = (goal_fx - freq_ff <= inc) ? goal_fx : freq_ff + inc;
        else if (freq_ff > goal_fx)
            stepped = (freq_ff - goal_fx <= inc) ? goal_fx : freq_ff - inc;
        else
            stepped = freq_ff;
        at_goal = freq_ff == goal_fx;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state_ff      <= ST_IDLE;
            freq_ff       <= 32'h0000_0000;
            hold_cnt_ff   <= 16'h0000;
            acc_pend_ff   <= 1'b0;
            dec_pass_ff   <= 1'b0;
            need_fresh_ff <= 1'b0;
            block_ff      <= 1'b1;
        end else if (state_ff != ST_IDLE && !permit && cfg_ff.stop_act == ACT_COAST) begin
            // coast: output blocked at once, frequency dropped
            state_ff      <= ST_IDLE;
            freq_ff       <= 32'h0000_0000;
            block_ff      <= 1'b1;
            acc_pend_ff   <= 1'b0;
            need_fresh_ff <= 1'b1;
        end else if (state_ff != ST_IDLE && state_ff != ST_QHALT && !permit) begin
            // permit loss under a ramp action
            state_ff      <= ST_QHALT;
            acc_pend_ff   <= 1'b0;
            dec_pass_ff   <= 1'b0;
            need_fresh_ff <= cfg_ff.stop_act == ACT_QHALT;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff      <= ST_RUN;
                        block_ff      <= 1'b0;
                        need_fresh_ff <= 1'b0;
                        // arm the hold for this run command only
                        acc_pend_ff   <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!run_lvl) begin
                        state_ff    <= ST_STOPPING;
                        acc_pend_ff <= 1'b0;
                        // stop command only, no brake control, above hold point
                        dec_pass_ff <= dec_dw_en && !cfg_ff.brake_ctl && cur > dec_dwf;
                    end else begin
                        if (tick_ff)
                            freq_ff <= stepped;
                        if (dw_goal && at_goal) begin
                            state_ff    <= ST_ACC_HOLD;
                            hold_cnt_ff <= 16'h0000;
                        end else if (!dw_goal || goal_fx < freq_ff) begin
                            acc_pend_ff <= 1'b0;
                        end
                    end
                end
                ST_ACC_HOLD: begin
                    if (!run_lvl) begin
                        state_ff    <= ST_STOPPING;
                        acc_pend_ff <= 1'b0;
                        dec_pass_ff <= dec_dw_en && !cfg_ff.brake_ctl && cur > dec_dwf;
                    end else if (32'(hold_cnt_ff) >= acc_hold_lim) begin
                        // hold over, resume toward the original target
                        state_ff    <= ST_RUN;
                        acc_pend_ff <= 1'b0;
                    end else if (tick_ff) begin
                        hold_cnt_ff <= hold_cnt_ff + 16'h0001;
                    end
                end
                ST_STOPPING: begin
                    if (run_lvl) begin
                        state_ff    <= ST_RUN;
                        dec_pass_ff <= 1'b0;
                    end else begin
                        if (tick_ff)
                            freq_ff <= stepped;
                        if (at_goal && dec_pass_ff) begin
                            state_ff    <= ST_DEC_HOLD;
                            hold_cnt_ff <= 16'h0000;
                            dec_pass_ff <= 1'b0;
                        end else if (cur == 16'h0000 && !dec_pass_ff) begin
                            state_ff <= ST_IDLE;
                            block_ff <= 1'b1;
                        end
                    end
                end
                ST_DEC_HOLD: begin
                    if (run_lvl) begin
                        state_ff <= ST_RUN;
                    end else if (32'(hold_cnt_ff) >= dec_hold_lim) begin
                        state_ff <= ST_STOPPING;
                    end else if (tick_ff) begin
                        hold_cnt_ff <= hold_cnt_ff + 16'h0001;
                    end
                end
                ST_QHALT: begin
                    if (cfg_ff.stop_act == ACT_QRESUME && permit && run_lvl) begin
                        state_ff <= ST_RUN;
                    end else begin
                        if (tick_ff)
                            freq_ff <= stepped;
                        if (cur == 16'h0000) begin
                            state_ff <= ST_IDLE;
                            block_ff <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    block_ff <= 1'b1;
                end
            endcase
        end
    end

    assign FREQ_REF  = freq_ff[FRAC_W +: 16];
    assign OUT_BLOCK = block_ff;

endmodule

`default_nettype wire

/* File: dv/rpds_monitor.sv */
// port checker for the run permit and dwell sequencer
`default_nettype none

module rpds_monitor (
    input wire logic        CORE_CLK,  // core clock
    input wire logic        RESET_N,   // sync reset, active low
    input wire logic        PSEL,      // apb select
    input wire logic        PENABLE,   // apb enable
    input wire logic [31:0] PRDATA,    // apb read data
    input wire logic        PREADY,    // apb ready
    input wire logic        PSLVERR,   // apb error
    input wire logic [15:0] FREQ_REF,  // frequency reference
    input wire logic        OUT_BLOCK  // output blocked
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    a_ready_next: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
    a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
    a_ready_cause: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
    a_ready_setup: assert property (PREADY |-> $past(PSEL && !PENABLE)) else $error("ready without setup");
    a_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("error with data");
    a_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA)) else $error("read data moved");
    a_block_zero: assert property (OUT_BLOCK |-> FREQ_REF == 16'h0) else $error("blocked but freq set");
    // the reference never changes on two edges in a row
    a_freq_step: assert property (!$stable(FREQ_REF) |=> $stable(FREQ_REF)) else $error("freq off tick");
endmodule

////////////////////////////////////////////////////////////////
bind rpds_sequencer rpds_monitor u_mon (.CORE_CLK, .RESET_N, .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR,
    .FREQ_REF, .OUT_BLOCK);

`default_nettype wire

/* File: dv/rpds_term_model.sv */
// far-side model: terminal block and run line
`default_nettype none

module rpds_term_model (
    input  wire logic       clk,    // core clock
    input  wire logic [2:0] slot,   // terminal carrying the permit
    input  wire logic       permit, // wanted permit level
    input  wire logic       run,    // wanted run level
    output logic      [4:0] term,   // terminal levels, unused ones low
    output logic            run_o   // run line
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        term  <= 5'(permit) << slot;
        run_o <= run;
    end
endmodule

`default_nettype wire

/* File: dv/rpds_sequencer_tb_top.sv */
// self-checking bench for the run permit and dwell sequencer
`default_nettype none

module rpds_sequencer_tb_top;
    import rpds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, penable, pwrite, run, permit, pready, pslverr, oblk, run_o;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  term;
    logic [15:0] freq;
    int          miscompares, tests_run;
    // tick of 10 clocks: a tenth of a second is 1000 clocks
    rpds_sequencer #(.TICK_CYC(10)) dut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TERM_IN(term), .RUN_IN(run_o), .FREQ_REF(freq), .OUT_BLOCK(oblk));
    rpds_term_model far (.clk(clk), .slot(3'h2), .permit(permit), .run(run), .term(term), .run_o(run_o));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q & {1'b1, m}, e);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // whole sequence needs about 12000 clocks; a hung handshake stops here
    initial begin
        #480000;
        miscompares++;
        finish_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, permit} = '0;
        rst_n = 1'b0;
        cyc(6);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 33'h1, 32'h3F);
        rd(OFS_ACC_DW, 33'h1F4, 32'hFFFFFFFF);
        rd(OFS_DEC_DW, 33'h1F4, 32'hFFFFFFFF);
        rd(OFS_QHALT, 33'h32, 32'hFFFF);
        rd(8'h24, 33'h1_0000_0000, 32'hFFFFFFFF);
        wr(OFS_QHALT, 32'h1B58);
        rd(OFS_QHALT, 33'h1770, 32'hFFFF);
        wr(OFS_TERMSEL, 32'h0000D000);
        wr(OFS_RAMP, 32'h00010001);
        wr(OFS_TARGET, 32'h0BB8);
        wr(OFS_ACC_DW, 32'h000203E8);
        permit <= 1'b1;
        run <= 1'b1;
        cyc(600);
        rd(OFS_STATUS, 33'h2_03E8, 32'h7FFFF);
        cyc(2200);
        rd(OFS_STATUS, 33'h1_0BB8, 32'h7FFFF);
        permit <= 1'b0;
        cyc(8);
        chk({16'h0, oblk, freq}, 33'h1_0000);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_QHALT, 32'h1);
        wr(OFS_ACC_DW, 32'h00020000);
        permit <= 1'b1;
        run <= 1'b0;
        cyc(10);
        run <= 1'b1;
        cyc(800);
        rd(OFS_STATUS, 33'h1_0BB8, 32'h7FFFF);
        permit <= 1'b0;
        cyc(20);
        rd(OFS_STATUS, 33'h5_0000, 32'h170000);
        cyc(800);
        chk({16'h0, oblk, freq}, 33'h1_0000);
        permit <= 1'b1;
        cyc(300);
        rd(OFS_STATUS, 33'h10_0000, 32'h170000);
        run <= 1'b0;
        cyc(10);
        run <= 1'b1;
        cyc(100);
        rd(OFS_STATUS, 33'h1_0000, 32'h170000);
        wr(OFS_CTRL, 32'h5);
        permit <= 1'b0;
        cyc(800);
        permit <= 1'b1;
        cyc(100);
        rd(OFS_STATUS, 33'h1_0000, 32'h170000);
        wr(OFS_DEC_DW, 32'h000203E8);
        cyc(600);
        run <= 1'b0;
        cyc(500);
        rd(OFS_STATUS, 33'h4_03E8, 32'h7FFFF);
        cyc(2600);
        rd(OFS_STATUS, 33'h10_0000, 32'h17FFFF);
        wr(OFS_CTRL, 32'hD);
        run <= 1'b1;
        cyc(800);
        run <= 1'b0;
        cyc(400);
        rd(OFS_STATUS, 33'h3_0000, 32'h70000);
        wr(OFS_CTRL, 32'h0);
        permit <= 1'b0;
        run <= 1'b1;
        cyc(100);
        rd(OFS_STATUS, 33'h1_0000, 32'h170000);
        wr(OFS_CTRL, 32'h10);
        wr(OFS_ACC_DW, 32'h000203E8);
        run <= 1'b0;
        cyc(700);
        run <= 1'b1;
        cyc(600);
        rd(OFS_STATUS, 33'h1_0BB8, 32'h7FFFF);
        finish_test;
    end
endmodule

`default_nettype wire
